/* File: verilog/trig_seq_pkg.sv */
/*
 * constants, field layout and types of the layered trigger sequencer.
 * assumes a 32-bit register bus with word-aligned registers and a
 * single system clock; only this package is shared between files.
 */
package trig_seq_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL  = 8'h00; // control
	localparam logic [7:0] OFS_LEVEL = 8'h04; // analog level
	localparam logic [7:0] OFS_CMD   = 8'h08; // command pulses
	localparam logic [7:0] OFS_STAT  = 8'h0c; // machine status
	localparam logic [7:0] OFS_IRQST = 8'h10; // sticky events
	localparam logic [7:0] OFS_IRQMK = 8'h14; // event mask

	// control field positions
	localparam int CTL_CONT  = 0;  // continuous initiation
	localparam int CTL_SRC   = 1;  // source select, 2 bits
	localparam int CTL_SLOPE = 3;  // 1 = falling slope
	localparam int CTL_DEND  = 4;  // 1 = done at end frequency
	localparam int CTL_CNT   = 8;  // exit count, up to 8 bits

	// level register field positions
	localparam int LVL_LEVEL = 0;  // threshold
	localparam int LVL_HYST  = 8;  // hysteresis

	// command bits
	localparam int CMD_INIT  = 0;  // initiate immediate
	localparam int CMD_ABORT = 1;  // abort
	localparam int CMD_RESET = 2;  // reset: idle, default mode and source
	localparam int CMD_IMM   = 3;  // one-shot detection bypass
	localparam int CMD_TRG   = 4;  // software bus trigger

	// status field positions
	localparam int STA_STATE = 0;  // state code, 2 bits
	localparam int STA_PEND  = 2;  // operation pending
	localparam int STA_EXITS = 8;  // downward exits so far

	// interrupt bits
	localparam int IRQ_START = 0;  // sweep started
	localparam int IRQ_DONE  = 1;  // returned to idle
	localparam int IRQ_ERR   = 2;  // misplaced immediate command
	localparam int IRQ_W     = 3;

	// reset values
	localparam logic [7:0] RST_COUNT = 8'h01;
	localparam logic [7:0] RST_LEVEL = 8'h80;
	localparam logic [7:0] RST_HYST  = 8'h04;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_INIT  = 2'b01,
		ST_EVDET = 2'b10,
		ST_SEQOP = 2'b11
	} trig_state_t;

	typedef enum logic [1:0] {
		SRC_IMM = 2'b00,
		SRC_BUS = 2'b01,
		SRC_EXT = 2'b10,
		SRC_ANA = 2'b11
	} trig_src_t;

endpackage

/* File: verilog/trig_event_detect.sv */
/*
 * event detector of the detection state: picks the selected source
 * and qualifies external edges and the analog level crossing.
 * assumes all inputs synchronous to clk_sys; output is combinational.
 */
`timescale 1ns/1ps
module trig_event_detect #(
	parameter int ANA_W = 8
) (
	input  wire logic                    clk_sys,
	input  wire logic                    rst_b,
	input  wire trig_seq_pkg::trig_src_t srcSel,
	input  wire logic                    slopeFall,
	input  wire logic [ANA_W-1:0]        level,
	input  wire logic [ANA_W-1:0]        hyst,
	input  wire logic [ANA_W-1:0]        sample,
	input  wire logic                    extTrig,
	input  wire logic                    busTrig,
	output logic                         eventHit
);
	import trig_seq_pkg::*;

	logic             extPrev_q; // last external level
	logic             armed_q;   // analog crossing armed
	logic [ANA_W:0]   sampW;     // widened sample
	logic [ANA_W:0]   levW;      // widened level
	logic [ANA_W:0]   hysW;      // widened hysteresis
	logic             anaArm;    // beyond hysteresis band
	logic             anaFire;   // qualified crossing

	// widen so sums cannot wrap
	assign sampW = {1'b0, sample};
	assign levW  = {1'b0, level};
	assign hysW  = {1'b0, hyst};

	// arm once the signal sits beyond the band, fire at the level
	assign anaArm  = slopeFall ? (sampW >= levW + hysW)
	                           : (sampW + hysW <= levW);
	assign anaFire = armed_q && (slopeFall ? (sample <= level)
	                                       : (sample >= level));

	// external edge history, reset high so a held pin is no edge
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			extPrev_q <= 1'b1;
		end else begin
			extPrev_q <= extTrig;
		end
	end

	// analog arming, disarmed by each crossing
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			armed_q <= 1'b0;
		end else if (anaFire) begin
			armed_q <= 1'b0;
		end else if (anaArm) begin
			armed_q <= 1'b1;
		end
	end

	// source selection
	always_comb begin
		unique case (srcSel)
			SRC_IMM: eventHit = 1'b1;
			SRC_BUS: eventHit = busTrig;
			SRC_EXT: eventHit = extTrig && !extPrev_q;
			SRC_ANA: eventHit = anaFire;
		endcase
	end

endmodule

/* File: verilog/layered_trigger_sequencer.sv */
/*
 * layered trigger sequencer: idle, initiate, one event-detection
 * layer and sequence operation, with an ahb-lite register slave and
 * a masked level interrupt.
 * assumes one slave on the bus, zero wait states, word transfers,
 * synchronous trigger inputs and completion pulses from the sweep.
 */
`timescale 1ns/1ps
module layered_trigger_sequencer #(
	parameter int CNT_W = 8, // exit count width
	parameter int ANA_W = 8  // analog sample width
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic [31:0]            hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic              extTrig,
	input  wire logic              busGet,
	input  wire logic [ANA_W-1:0]  anaSample,
	input  wire logic              atStartFreq,
	input  wire logic              atEndFreq,
	output logic                   sweepStart,
	output logic                   opPending,
	output trig_seq_pkg::trig_state_t trigState,
	output logic                   irq
);
	import trig_seq_pkg::*;

	// refuse widths the register fields cannot hold
	generate
		if (CNT_W < 1 || CNT_W > 8 || ANA_W < 1 || ANA_W > 8) begin : g_chk
			$error("CNT_W and ANA_W must lie in 1..8");
		end
	endgenerate

	// bus side
	logic              wrPend_q;   // write data phase due
	logic [7:0]        wrAddr_q;   // latched write offset
	logic              addrTake;   // address phase accepted
	logic [31:0]       rdMux;      // read data select
	// configuration
	logic              contEn_q;   // continuous initiation
	trig_src_t         src_q;      // trigger source
	logic              slopeFall_q;// analog slope
	logic              doneEnd_q;  // completion at end freq
	logic [CNT_W-1:0]  count_q;    // programmed exit count
	logic [ANA_W-1:0]  level_q;    // analog threshold
	logic [ANA_W-1:0]  hyst_q;     // analog hysteresis
	logic [IRQ_W-1:0]  irqSt_q;    // sticky events
	logic [IRQ_W-1:0]  irqMk_q;    // event mask
	// command pulses
	logic              cmdWr;      // command register written
	logic              initCmd;    // initiate immediate
	logic              abortCmd;   // abort
	logic              resetCmd;   // reset
	logic              immCmd;     // one-shot bypass
	logic              forceIdle;  // abort or reset
	// machine
	trig_state_t       state_q;    // current state
	trig_state_t       stateD;     // next state
	logic              down_q;     // entered on downward path
	logic              downD;
	logic [CNT_W-1:0]  exits_q;    // downward exits so far
	logic [CNT_W-1:0]  exitsD;
	logic              startD;     // sweep start next cycle
	logic              eventHit;   // selected source fired
	logic              actDone;    // selected completion
	logic [IRQ_W-1:0]  irqEv;      // events this cycle

	// address phase is taken when the bus is ready
	assign addrTake = hsel && htrans[1] && hready;

	// data phase command decode
	assign cmdWr     = wrPend_q && (wrAddr_q == OFS_CMD);
	assign initCmd   = cmdWr && hwdata[CMD_INIT];
	assign abortCmd  = cmdWr && hwdata[CMD_ABORT];
	assign resetCmd  = cmdWr && hwdata[CMD_RESET];
	assign immCmd    = cmdWr && hwdata[CMD_IMM];
	assign forceIdle = abortCmd || resetCmd;

	// completion edge as configured
	assign actDone = doneEnd_q ? atEndFreq : atStartFreq;

	// source qualifier
	trig_event_detect #(
		.ANA_W (ANA_W)
	) u_detect (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.srcSel    (src_q),
		.slopeFall (slopeFall_q),
		.level     (level_q),
		.hyst      (hyst_q),
		.sample    (anaSample),
		.extTrig   (extTrig),
		.busTrig   (busGet || (cmdWr && hwdata[CMD_TRG])),
		.eventHit  (eventHit)
	);

	// latch write address phase; only whole words are written
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
		end else begin
			wrPend_q <= addrTake && hwrite && (hsize == 3'b010);
			wrAddr_q <= haddr[7:0];
		end
	end

	// read data select, sampled in the address phase
	always_comb begin
		rdMux = 32'h0000_0000;
		unique case (haddr[7:0])
			OFS_CTRL: begin
				rdMux[CTL_CONT]            = contEn_q;
				rdMux[CTL_SRC +: 2]        = src_q;
				rdMux[CTL_SLOPE]           = slopeFall_q;
				rdMux[CTL_DEND]            = doneEnd_q;
				rdMux[CTL_CNT +: CNT_W]    = count_q;
			end
			OFS_LEVEL: begin
				rdMux[LVL_LEVEL +: ANA_W]  = level_q;
				rdMux[LVL_HYST +: ANA_W]   = hyst_q;
			end
			OFS_STAT: begin
				rdMux[STA_STATE +: 2]      = state_q;
				rdMux[STA_PEND]            = opPending;
				rdMux[STA_EXITS +: CNT_W]  = exits_q;
			end
			OFS_IRQST: rdMux[IRQ_W-1:0]  = irqSt_q;
			OFS_IRQMK: rdMux[IRQ_W-1:0]  = irqMk_q;
			default:   rdMux = 32'h0000_0000; // unmapped reads zero
		endcase
	end

	// read data stands through the data phase
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hrdata <= 32'h0000_0000;
		end else if (addrTake && !hwrite) begin
			hrdata <= rdMux;
		end
	end

	// zero wait states, always okay
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// control register; reset command restores default mode and source only
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			contEn_q    <= 1'b0;
			src_q       <= SRC_IMM;
			slopeFall_q <= 1'b0;
			doneEnd_q   <= 1'b0;
			count_q     <= CNT_W'(RST_COUNT);
		end else if (resetCmd) begin
			contEn_q    <= 1'b0;
			src_q       <= SRC_IMM;
		end else if (wrPend_q && wrAddr_q == OFS_CTRL) begin
			contEn_q    <= hwdata[CTL_CONT];
			src_q       <= trig_src_t'(hwdata[CTL_SRC +: 2]);
			slopeFall_q <= hwdata[CTL_SLOPE];
			doneEnd_q   <= hwdata[CTL_DEND];
			count_q     <= hwdata[CTL_CNT +: CNT_W];
		end
	end

	// analog qualification settings
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			level_q <= ANA_W'(RST_LEVEL);
			hyst_q  <= ANA_W'(RST_HYST);
		end else if (wrPend_q && wrAddr_q == OFS_LEVEL) begin
			level_q <= hwdata[LVL_LEVEL +: ANA_W];
			hyst_q  <= hwdata[LVL_HYST +: ANA_W];
		end
	end

	// next state of the trigger layers
	always_comb begin
		stateD = state_q;
		downD  = down_q;
		exitsD = exits_q;
		startD = 1'b0;
		if (forceIdle) begin
			stateD = ST_IDLE;
			downD  = 1'b1;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					// leave on demand or continuous mode
					if (initCmd || contEn_q) begin
						stateD = ST_INIT;
						downD  = 1'b1;
					end
				end
				ST_INIT: begin
					if (down_q) begin
						stateD = ST_EVDET;
						exitsD = '0;
					end else if (contEn_q) begin
						stateD = ST_EVDET;
						downD  = 1'b1;
						exitsD = '0;
					end else begin
						stateD = ST_IDLE;
					end
				end
				ST_EVDET: begin
					// count satisfied: upward, else wait for event
					if (exits_q >= count_q) begin
						stateD = ST_INIT;
						downD  = 1'b0;
					end else if (eventHit || immCmd) begin
						stateD = ST_SEQOP;
						downD  = 1'b1;
						exitsD = exits_q + 1'b1;
						startD = 1'b1;
					end
				end
				ST_SEQOP: begin
					// hold until the sweep reports completion
					if (actDone) begin
						stateD = ST_EVDET;
						downD  = 1'b0;
					end
				end
			endcase
		end
	end

	// machine registers, one step per clock
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			down_q  <= 1'b1;
			exits_q <= '0;
		end else begin
			state_q <= stateD;
			down_q  <= downD;
			exits_q <= exitsD;
		end
	end

	// registered outputs of the machine
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			opPending  <= 1'b0;
			sweepStart <= 1'b0;
			trigState  <= ST_IDLE;
		end else begin
			opPending  <= (stateD != ST_IDLE);
			sweepStart <= startD;
			trigState  <= stateD;
		end
	end

	// events: sweep start, back to idle, misplaced bypass
	assign irqEv[IRQ_START] = startD;
	assign irqEv[IRQ_DONE]  = (state_q != ST_IDLE) && (stateD == ST_IDLE);
	assign irqEv[IRQ_ERR]   = immCmd && (state_q != ST_EVDET);

	// sticky status, write one to clear, a new event wins
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irqSt_q <= '0;
		end else if (wrPend_q && wrAddr_q == OFS_IRQST) begin
			irqSt_q <= (irqSt_q & ~hwdata[IRQ_W-1:0]) | irqEv;
		end else begin
			irqSt_q <= irqSt_q | irqEv;
		end
	end

	// mask register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irqMk_q <= '0;
		end else if (wrPend_q && wrAddr_q == OFS_IRQMK) begin
			irqMk_q <= hwdata[IRQ_W-1:0];
		end
	end

	// interrupt level, one cycle behind the status bits
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irqSt_q & irqMk_q);
		end
	end

	// abort or reset land in idle
	property p_forceIdle;
		@(posedge clk_sys) disable iff (!rst_b)
		forceIdle |=> state_q == ST_IDLE;
	endproperty
	a_forceIdle: assert property (p_forceIdle)
		else $error("abort or reset did not reach idle");

	// only neighbour steps or a forced idle
	property p_adjacent;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_q != $past(state_q)) |-> (state_q == ST_IDLE
			|| int'(state_q) == int'($past(state_q)) + 1
			|| int'(state_q) == int'($past(state_q)) - 1);
	endproperty
	a_adjacent: assert property (p_adjacent)
		else $error("state jumped over a layer");

	// idle holds without a cause
	property p_idleWait;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_q == ST_IDLE && !initCmd && !contEn_q) |=>
			state_q == ST_IDLE;
	endproperty
	a_idleWait: assert property (p_idleWait)
		else $error("idle left without initiation");

	// reset command restores default mode and source
	property p_rstDefaults;
		@(posedge clk_sys) disable iff (!rst_b)
		resetCmd |=> (!contEn_q && src_q == SRC_IMM);
	endproperty
	a_rstDefaults: assert property (p_rstDefaults)
		else $error("reset did not restore mode and source");

	// pending mirrors non-idle
	property p_pending;
		@(posedge clk_sys) disable iff (!rst_b)
		opPending == (state_q != ST_IDLE);
	endproperty
	a_pending: assert property (p_pending)
		else $error("pending flag disagrees with state");

	// downward initiate passes through
	property p_initDown;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_q == ST_INIT && down_q && !forceIdle) |=>
			state_q == ST_EVDET;
	endproperty
	a_initDown: assert property (p_initDown)
		else $error("downward initiate did not pass");

	// upward initiate follows continuous mode
	property p_initUp;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_q == ST_INIT && !down_q && !forceIdle) |=>
			state_q == ($past(contEn_q) ? ST_EVDET : ST_IDLE);
	endproperty
	a_initUp: assert property (p_initUp)
		else $error("upward initiate took wrong exit");

	// downward exit only on an event or bypass
	property p_evExit;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_q == ST_SEQOP && $past(state_q) == ST_EVDET) |->
			($past(eventHit) || $past(immCmd));
	endproperty
	a_evExit: assert property (p_evExit)
		else $error("detection exited without an event");

	// immediate source never waits
	property p_immSrc;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_q == ST_EVDET && src_q == SRC_IMM
			&& exits_q < count_q && !forceIdle) |=>
			state_q == ST_SEQOP && sweepStart;
	endproperty
	a_immSrc: assert property (p_immSrc)
		else $error("immediate source did not start sweep");

	// count reached sends the machine up
	property p_countUp;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_q == ST_EVDET && exits_q >= count_q && !forceIdle)
			|=> state_q == ST_INIT;
	endproperty
	a_countUp: assert property (p_countUp)
		else $error("exit count reached but no upward exit");

	// operation holds until completion
	property p_seqHold;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_q == ST_SEQOP && !actDone && !forceIdle) |=>
			state_q == ST_SEQOP;
	endproperty
	a_seqHold: assert property (p_seqHold)
		else $error("operation left before completion");

endmodule

/* File: tb/sweep_partner.sv */
/*
 * far-side model: trigger sources and the sweep hardware.
 * assumes request pulses from the bench, synchronous to clk_sys.
 */
`timescale 1ns/1ps
module sweep_partner (
	input  wire logic       clk_sys,
	input  wire logic       sweepStart,
	input  wire logic       extReq,
	input  wire logic       busReq,
	input  wire logic [3:0] dly,
	output logic            extTrig,
	output logic            busGet,
	output logic            atStartFreq,
	output logic            atEndFreq
);
	int cnt = 0; // sweep progress, 0 when idle
	int ext = 0; // external pulse cycles left
	// quiet lines at time zero
	initial begin
		extTrig = 0;
		busGet = 0;
		atStartFreq = 0;
		atEndFreq = 0;
	end
	// trigger sources: bus pulse, external low-high-low
	always @(posedge clk_sys) begin
		busGet <= busReq;
		ext = extReq ? 3 : (ext > 0 ? ext - 1 : 0);
		extTrig <= (ext > 0);
	end
	// sweep: start freq after dly, end freq dly+1 later
	always @(posedge clk_sys) begin
		cnt = sweepStart ? 1 : (cnt > 0 ? cnt + 1 : 0);
		atStartFreq <= (cnt == dly + 1);
		atEndFreq <= (cnt == 2 * dly + 2);
		if (cnt > 2 * dly + 2)
			cnt = 0;
	end
endmodule

/* File: tb/testbench.sv */
/*
 * self-checking bench of the trigger sequencer over ahb-lite.
 * assumes zero-wait slave and the partner model beside it.
 */
`timescale 1ns/1ps
module testbench;
	import trig_seq_pkg::*;
	localparam logic [15:0] ADJ = 16'hdf73; // legal {old,new} steps
	logic        clk_sys = 0;
	logic        rst_b = 0;
	logic        hsel = 0;
	logic [31:0] haddr = 0;
	logic [1:0]  htrans = 0;
	logic        hwrite = 0;
	logic [31:0] hwdata = 0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        extTrig, busGet, atStartFreq, atEndFreq;
	logic        extReq = 0;
	logic        busReq = 0;
	logic [3:0]  dly = 2;
	logic [7:0]  anaSample = 0;
	logic        sweepStart, opPending, irq;
	trig_state_t trigState;
	logic [1:0]  pSt = 0;      // state seen last edge
	logic        pDone = 0;    // selected completion last edge
	logic        endMode = 0;  // done at end frequency
	logic [31:0] q;
	int          failCount = 0;
	int          checkCount = 0;
	int          seed = 77639;
	int          sw, idleN;
	logic        seenInit;
	// clock, 100 MHz
	always #5 clk_sys = ~clk_sys;
	layered_trigger_sequencer layered_trigger_sequencer_inst (
		.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .extTrig(extTrig),
		.busGet(busGet), .anaSample(anaSample),
		.atStartFreq(atStartFreq), .atEndFreq(atEndFreq),
		.sweepStart(sweepStart), .opPending(opPending),
		.trigState(trigState), .irq(irq));
	sweep_partner sweep_partner_inst (
		.clk_sys(clk_sys), .sweepStart(sweepStart), .extReq(extReq),
		.busReq(busReq), .dly(dly), .extTrig(extTrig), .busGet(busGet),
		.atStartFreq(atStartFreq), .atEndFreq(atEndFreq));
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			failCount++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// one ahb single transfer, read data taken at data-phase edge
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		q = hrdata;
		chk({31'h0, hresp}, 0);
	endtask
	// wait for a state code, bounded
	task automatic waitSt(input trig_state_t s);
		int n;
		n = 0;
		while (trigState !== s && n < 300) begin
			@(posedge clk_sys);
			n++;
		end
		chk({30'h0, trigState}, {30'h0, s});
	endtask
	// print counts, verdict, stop
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// per-cycle model of the state walk
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			pSt = 0;
		end else begin
			chk({31'h0, opPending}, {31'h0, trigState != ST_IDLE});
			chk({31'h0, sweepStart}, {31'h0, trigState == 3 && pSt == 2});
			chk({31'h0, ADJ[{pSt, trigState}]}, 1);
			if (pSt == 3 && trigState == 2)
				chk({31'h0, pDone}, 1);
			pSt = trigState;
			pDone = endMode ? atEndFreq : atStartFreq;
		end
	end
	// watchdog
	initial begin
		#300000;
		failCount++;
		giveVerdict();
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_b <= 1;
		chk({30'h0, trigState}, 0);
		// register reset values and unmapped place
		ahb(1, 8'h18, 32'hffffffff);
		ahb(0, 8'h18, 0); chk(q, 0);
		ahb(0, OFS_CTRL, 0); chk(q, 32'(RST_COUNT) << CTL_CNT);
		ahb(0, OFS_LEVEL, 0); chk(q, {16'h0, RST_HYST, RST_LEVEL});
		ahb(0, OFS_STAT, 0); chk(q, 0);
		ahb(0, OFS_IRQMK, 0); chk(q, 0);
		$display("test registers done");
		// single sweep with mask closed, then opened, then cleared
		ahb(1, OFS_CMD, 1 << CMD_INIT);
		waitSt(ST_SEQOP);
		waitSt(ST_IDLE);
		ahb(0, OFS_IRQST, 0); chk(q, 3);
		chk({31'h0, irq}, 0);
		ahb(1, OFS_IRQMK, 7);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, irq}, 1);
		ahb(1, OFS_IRQST, 7);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, irq}, 0);
		ahb(0, OFS_IRQST, 0); chk(q, 0);
		$display("test single sweep done");
		// sources: bus, soft trigger, external, analog rise and fall
		for (int k = 0; k < 5; k++) begin
			endMode = (k >= 2);
			dly <= 4'(k * 3);
			ahb(1, OFS_CTRL, 32'h100 | endMode << 4
				| (k < 2 ? 2 : k > 3 ? 14 : k * 2));
			ahb(1, OFS_CMD, 1 << CMD_INIT);
			waitSt(ST_EVDET);
			repeat (6) begin
				@(posedge clk_sys);
				// low samples arm rising, high samples arm falling
				anaSample <= (k == 4) ? 8'($random(seed)) | 8'hc0
				                      : 8'($random(seed)) & 8'h3f;
			end
			chk({30'h0, trigState}, ST_EVDET);
			case (k)
				0: busReq <= 1;
				1: ahb(1, OFS_CMD, 1 << CMD_TRG);
				2: extReq <= 1;
				default: anaSample <= RST_LEVEL;
			endcase
			@(posedge clk_sys);
			busReq <= 0;
			extReq <= 0;
			waitSt(ST_SEQOP);
			waitSt(ST_IDLE);
		end
		$display("test sources done");
		// one-shot bypass in detection, then misplaced in idle
		ahb(1, OFS_IRQST, 7);
		endMode = 0;
		ahb(1, OFS_CTRL, 32'h102);
		ahb(1, OFS_CMD, 1 << CMD_INIT);
		waitSt(ST_EVDET);
		ahb(1, OFS_CMD, 1 << CMD_IMM);
		waitSt(ST_SEQOP);
		waitSt(ST_IDLE);
		ahb(1, OFS_CMD, 1 << CMD_IMM);
		ahb(0, OFS_IRQST, 0); chk(q, 7);
		chk({30'h0, trigState}, ST_IDLE);
		$display("test bypass done");
		// continuous, count 2, then abort and reset command
		endMode = 0;
		ahb(1, OFS_CTRL, 32'h201);
		sw = 0;
		idleN = 0;
		seenInit = 0;
		repeat (150) begin
			@(posedge clk_sys);
			idleN += (trigState == ST_IDLE);
			sw += sweepStart;
			// two sweep starts between initiate visits, one cycle each
			if (trigState == ST_INIT) begin
				if (seenInit)
					chk(sw, 2);
				sw = 0;
				seenInit = 1;
			end
		end
		chk(idleN < 3, 1);
		ahb(1, OFS_CMD, 1 << CMD_ABORT);
		@(posedge clk_sys);
		chk({30'h0, trigState}, ST_IDLE);
		ahb(1, OFS_CMD, 1 << CMD_RESET);
		repeat (6) @(posedge clk_sys);
		chk({30'h0, trigState}, ST_IDLE);
		ahb(0, OFS_CTRL, 0); chk(q, 32'h200);
		$display("test continuous done");
		giveVerdict();
	end
endmodule
